/* File: rtl/rsd_pkg.sv */
package rsd_pkg;
    localparam int RSD_W = 8;
    localparam int RSD_NIB = 4;
    localparam int RSD_LSB = 0;
    localparam logic [RSD_W-1:0] RSD_ZERO = 8'h00;
    localparam logic [RSD_W-1:0] RSD_ACC_RST = 8'h00;
    localparam logic RSD_FLAG_RST = 1'h0;
    localparam logic RSD_DEST_ACC = 1'h0;
    localparam logic RSD_DEST_FILE = 1'h1;

    typedef enum logic [1:0] {
        RSD_OP_NONE,
        RSD_OP_ROT,
        RSD_OP_SUB
    } rsd_op_t;
endpackage

/* File: rtl/rsd_alu.sv */
`timescale 1ns/100ps
module rsd_alu
    import rsd_pkg::*;
(
    input wire logic [RSD_W-1:0] opnd_a,
    input wire logic [RSD_W-1:0] opnd_b,
    input wire logic carry_in,
    input wire logic sel_sub,
    output logic [RSD_W-1:0] result,
    output logic carry_out,
    output logic nib_out
);
    logic [RSD_W:0] diff;
    logic [RSD_NIB:0] ndiff;

    always_comb begin
        diff = {1'h0, opnd_b} - {1'h0, opnd_a};
        ndiff = {1'h0, opnd_b[RSD_NIB-1:RSD_LSB]}
            - {1'h0, opnd_a[RSD_NIB-1:RSD_LSB]};
        if (sel_sub) begin
            // Borrow inverted: carry set when a <= b
            result = diff[RSD_W-1:0]; // [RULE3]
            carry_out = ~diff[RSD_W]; // [RULE3]
            nib_out = ~ndiff[RSD_NIB]; // [RULE3]
        end else begin
            result = {carry_in, opnd_a[RSD_W-1:RSD_LSB+1]}; // [RULE1]
            carry_out = opnd_a[RSD_LSB]; // [RULE1]
            nib_out = 1'h0;
        end
    end
endmodule

/* File: rtl/rsd_datapath.sv */
`timescale 1ns/100ps
// Behaviour
// [RULE1] Rotate right moves old carry into bit 7 and bit 0 into carry.
// [RULE2] Rotate right writes the accumulator when dest is 0, the file when 1.
// [RULE3] Subtract takes immediate minus accumulator, sets carry and nibble.
// [RULE4] Subtract always writes the accumulator and never the file register.
// [RULE5] Subtract sets zero on a zero result; rotate changes only carry.
module rsd_datapath
    import rsd_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic rotate_right_op,
    input wire logic immediate_minus_accumulator_op,
    input wire logic dest_sel,
    input wire logic [RSD_W-1:0] file_rd_data,
    input wire logic [RSD_W-1:0] immediate,
    output logic [RSD_W-1:0] acc,
    output logic carry_flag,
    output logic nibble_borrow_inverse_flag,
    output logic zero_flag,
    output logic file_wr_en,
    output logic [RSD_W-1:0] file_wr_data
);
    logic rst_meta_ff;
    logic nxt_rst_meta;
    logic rst_sync_ff;
    logic nxt_rst_sync;
    logic rst_sync_b;
    rsd_op_t op;
    logic sel_sub;
    logic [RSD_W-1:0] alu_opnd;
    logic [RSD_W-1:0] alu_res;
    logic alu_c;
    logic alu_n;
    logic acc_load;
    logic file_load;
    logic [RSD_W-1:0] acc_ff;
    logic [RSD_W-1:0] nxt_acc;
    logic c_ff;
    logic nxt_c;
    logic n_ff;
    logic nxt_n;
    logic z_ff;
    logic nxt_z;
    logic we_ff;
    logic nxt_we;
    logic [RSD_W-1:0] wd_ff;
    logic [RSD_W-1:0] nxt_wd;

    // Both strobes high decode as subtract; the rotate is dropped
    function automatic rsd_op_t rsd_decode(
        input logic rot,
        input logic sub
    );
        rsd_op_t code;
        if (sub) begin
            code = RSD_OP_SUB;
        end else if (rot) begin
            code = RSD_OP_ROT;
        end else begin
            code = RSD_OP_NONE;
        end
        return code;
    endfunction

    function automatic logic rsd_to_file(
        input rsd_op_t code,
        input logic dest
    );
        return (code == RSD_OP_ROT) && (dest == RSD_DEST_FILE); // [RULE4]
    endfunction

    function automatic logic rsd_to_acc(
        input rsd_op_t code,
        input logic dest
    );
        logic hit;
        hit = 1'h0;
        case (code)
            RSD_OP_SUB: begin
                hit = 1'h1;
            end
            RSD_OP_ROT: begin
                hit = (dest == RSD_DEST_ACC);
            end
            default: begin
                hit = 1'h0;
            end
        endcase
        return hit;
    endfunction

    function automatic logic rsd_is_zero(
        input logic [RSD_W-1:0] value
    );
        return value == RSD_ZERO;
    endfunction

    // Release passes two flops; assertion stays asynchronous
    always_comb begin
        nxt_rst_meta = 1'h1;
        nxt_rst_sync = rst_meta_ff;
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_ff <= 1'h0;
            rst_sync_ff <= 1'h0;
        end else begin
            rst_meta_ff <= nxt_rst_meta;
            rst_sync_ff <= nxt_rst_sync;
        end
    end

    assign rst_sync_b = rst_sync_ff;

    always_comb begin
        op = rsd_decode(rotate_right_op, immediate_minus_accumulator_op);
        sel_sub = (op == RSD_OP_SUB);
        acc_load = rsd_to_acc(op, dest_sel);
        file_load = rsd_to_file(op, dest_sel);
    end

    // Subtract works on the accumulator, rotate on the file operand
    always_comb begin
        if (sel_sub) begin
            alu_opnd = acc_ff;
        end else begin
            alu_opnd = file_rd_data;
        end
    end

    rsd_alu u_alu (
        .opnd_a(alu_opnd),
        .opnd_b(immediate),
        .carry_in(c_ff),
        .sel_sub(sel_sub),
        .result(alu_res),
        .carry_out(alu_c),
        .nib_out(alu_n)
    );

    // Accumulator loads on subtract or on rotate aimed at it
    always_comb begin
        if (acc_load) begin
            nxt_acc = alu_res; // [RULE2] [RULE4]
        end else begin
            nxt_acc = acc_ff;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            acc_ff <= RSD_ACC_RST;
        end else begin
            acc_ff <= nxt_acc;
        end
    end

    // Rotate touches carry only; nibble and zero hold
    always_comb begin
        nxt_c = c_ff;
        nxt_n = n_ff;
        nxt_z = z_ff;
        case (op)
            RSD_OP_ROT: begin
                nxt_c = alu_c; // [RULE1] [RULE5]
            end
            RSD_OP_SUB: begin
                nxt_c = alu_c; // [RULE3]
                nxt_n = alu_n; // [RULE3]
                nxt_z = rsd_is_zero(alu_res); // [RULE5]
            end
            RSD_OP_NONE: begin
                nxt_c = c_ff;
            end
            default: begin
                nxt_c = c_ff;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            c_ff <= RSD_FLAG_RST;
            n_ff <= RSD_FLAG_RST;
            z_ff <= RSD_FLAG_RST;
        end else begin
            c_ff <= nxt_c;
            n_ff <= nxt_n;
            z_ff <= nxt_z;
        end
    end

    // Write strobe is a one-cycle pulse; data holds after it
    always_comb begin
        if (file_load) begin
            nxt_we = 1'h1; // [RULE2]
            nxt_wd = alu_res; // [RULE2]
        end else begin
            nxt_we = 1'h0;
            nxt_wd = wd_ff;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            we_ff <= 1'h0;
            wd_ff <= RSD_ACC_RST;
        end else begin
            we_ff <= nxt_we;
            wd_ff <= nxt_wd;
        end
    end

    assign acc = acc_ff;
    assign carry_flag = c_ff;
    assign nibble_borrow_inverse_flag = n_ff;
    assign zero_flag = z_ff;
    assign file_wr_en = we_ff;
    assign file_wr_data = wd_ff;
endmodule

/* File: tb/rsd_datapath_checker.sv */
`timescale 1ns/100ps
module rsd_datapath_checker (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic rotate_right_op,
    input wire logic immediate_minus_accumulator_op,
    input wire logic dest_sel,
    input wire logic [7:0] file_rd_data,
    input wire logic [7:0] immediate,
    input wire logic [7:0] acc,
    input wire logic carry_flag,
    input wire logic nibble_borrow_inverse_flag,
    input wire logic zero_flag,
    input wire logic file_wr_en,
    input wire logic [7:0] file_wr_data
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    wire s = immediate_minus_accumulator_op;
    wire r = rotate_right_op & ~s;
    chk_rot_carry: assert property (r |=>
        carry_flag == $past(file_rd_data[0]) && $stable(zero_flag))
        else $error("rotate carry wrong");
    chk_rot_dest: assert property (r |=>
        (file_wr_en ? file_wr_data : acc) == {$past(carry_flag),
        $past(file_rd_data[7:1])} && file_wr_en == $past(dest_sel))
        else $error("rotate result wrong");
    chk_sub_diff: assert property (s |=>
        acc == $past(immediate) - $past(acc) &&
        carry_flag == ($past(acc) <= $past(immediate)))
        else $error("subtract wrong");
    chk_sub_nib: assert property (s |=>
        nibble_borrow_inverse_flag ==
        ($past(acc[3:0]) <= $past(immediate[3:0])))
        else $error("nibble flag wrong");
    chk_sub_dest: assert property (s |=>
        !file_wr_en && zero_flag == (acc == 8'h00))
        else $error("subtract dest wrong");
endmodule
bind rsd_datapath rsd_datapath_checker chk (.*);

/* File: tb/rsd_datapath_tb.sv */
`timescale 1ns/100ps
module rsd_datapath_tb;
    logic clk_sys = 1'h0;
    logic rst_b = 1'h0;
    logic rotate_right_op = 1'h0;
    logic immediate_minus_accumulator_op = 1'h0;
    logic dest_sel = 1'h0;
    logic [7:0] file_rd_data = 8'h00;
    logic [7:0] immediate = 8'h00;
    logic [7:0] acc;
    logic carry_flag;
    logic nibble_borrow_inverse_flag;
    logic zero_flag;
    logic file_wr_en;
    logic [7:0] file_wr_data;
    logic [7:0] am = 8'h00;
    logic [2:0] fm = 3'h0;
    logic [8:0] wm = 9'h000;
    logic [2:0] fo;
    logic [8:0] wo;
    logic [31:0] rv;
    int errors = 0;
    int samples_checked = 0;
    int seed = 32'hdc4c;

    always #50 clk_sys = ~clk_sys;

    rsd_datapath uut (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .rotate_right_op(rotate_right_op),
        .immediate_minus_accumulator_op(immediate_minus_accumulator_op),
        .dest_sel(dest_sel),
        .file_rd_data(file_rd_data),
        .immediate(immediate),
        .acc(acc),
        .carry_flag(carry_flag),
        .nibble_borrow_inverse_flag(nibble_borrow_inverse_flag),
        .zero_flag(zero_flag),
        .file_wr_en(file_wr_en),
        .file_wr_data(file_wr_data)
    );

    assign fo = {carry_flag, nibble_borrow_inverse_flag, zero_flag};
    assign wo = {file_wr_en, file_wr_en ? file_wr_data : 8'h00};

    // Expected {carry, nibble, zero, acc} after a subtract
    function automatic logic [10:0] exp_sub(input logic [7:0] a, k);
        return {a <= k, a[3:0] <= k[3:0], k == a, k - a};
    endfunction

    // Expected {acc, carry, write} after a rotate
    function automatic logic [17:0] exp_rot(input logic c, d,
        input logic [7:0] a, f);
        if (d) begin
            return {a, f[0], 1'h1, c, f[7:1]};
        end
        return {c, f[7:1], f[0], 9'h000};
    endfunction

    task automatic report(input logic [8:0] got, input logic [8:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t %h %h", $time, got, exp);
        end
    endtask
    task automatic cmp_acc(input logic [7:0] got, input logic [7:0] exp);
        report({1'h0, got}, {1'h0, exp});
    endtask
    task automatic cmp_flags(input logic [2:0] got, input logic [2:0] exp);
        report({6'h00, got}, {6'h00, exp});
    endtask
    task automatic cmp_wr(input logic [8:0] got, input logic [8:0] exp);
        report(got, exp);
    endtask

    task automatic step(input logic r, s, d, input logic [7:0] f, k);
        @(posedge clk_sys);
        rotate_right_op <= r;
        immediate_minus_accumulator_op <= s;
        dest_sel <= d;
        file_rd_data <= f;
        immediate <= k;
        @(negedge clk_sys);
        cmp_acc(acc, am);
        cmp_flags(fo, fm);
        cmp_wr(wo, wm);
        wm = 9'h000;
        if (s) begin
            {fm, am} = exp_sub(am, k);
        end else if (r) begin
            {am, fm[2], wm} = exp_rot(fm[2], d, am, f);
        end
    endtask

    initial begin
        repeat (4) @(posedge clk_sys);
        rst_b <= 1'h1;
        repeat (2) step(1'h0, 1'h0, 1'h0, 8'h00, 8'h00);
        step(1'h1, 1'h1, 1'h1, 8'hFF, 8'h0F);
        step(1'h0, 1'h1, 1'h0, 8'h00, 8'h0F);
        step(1'h0, 1'h1, 1'h0, 8'h00, 8'h13);
        step(1'h0, 1'h1, 1'h0, 8'h00, 8'h20);
        step(1'h1, 1'h0, 1'h1, 8'h01, 8'h00);
        step(1'h1, 1'h0, 1'h0, 8'hE6, 8'h00);
        step(1'h1, 1'h0, 1'h1, 8'h80, 8'h00);
        $display("corner test done");
        repeat (400) begin
            rv = $random(seed);
            step(rv[0], rv[1], rv[2], rv[15:8], rv[23:16]);
        end
        step(1'h0, 1'h0, 1'h0, 8'h00, 8'h00);
        $display("random test done");
        give_verdict;
    end
    task automatic give_verdict;
        $display("checked %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
endmodule
